// ---- verilog/global_ctrl_pkg.sv ----
// global_ctrl_pkg: constants and carrier types for the global control,
// oscillator divider and long-line driver block.
// assumes clk is the on-chip oscillator as seen by the simulation (250 MHz).
package global_ctrl_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // clock and timing
    localparam int CLK_FREQ_MHZ = 250;
    // oscillator nominal and limits, in kHz
    localparam int OSC_NOM_KHZ = 8000;
    localparam int OSC_MIN_KHZ = 4000;
    localparam int OSC_MAX_KHZ = 10000;
    // power-on timeout and configuration memory clear time, in ns
    localparam int POR_TIME_NS = 20000;
    localparam int CLEAR_TIME_NS = 2000;
    localparam int POR_CYCLES_DEF = (POR_TIME_NS * CLK_FREQ_MHZ + 999) / 1000;
    localparam int CLEAR_CYCLES = (CLEAR_TIME_NS * CLK_FREQ_MHZ + 999) / 1000;

    ////////////////////////////////////////////////////////////////////////////
    // divider layout: taps at the 4th, 9th, 14th and 19th bit
    localparam int DIV_WIDTH = 19;
    localparam int TAP0_BIT = 3;
    localparam int TAP1_BIT = 8;
    localparam int TAP2_BIT = 13;
    localparam int TAP3_BIT = 18;
    // divider bit that feeds the configuration clock in master mode
    localparam int CFG_CLK_BIT = 0;

    ////////////////////////////////////////////////////////////////////////////
    // reset values
    localparam logic [1:0] TAP_SEL_RST = 2'h0;

    // divider tap choice
    typedef enum logic [1:0] {
        TAP_500K,
        TAP_16K,
        TAP_490,
        TAP_15
    } tap_sel_t;

    // source of a chip-wide control net
    typedef struct packed {
        logic fromPin; // 1: pin through input buffer, 0: internal node
        logic invert;  // invert the pin's sense
    } net_src_t;

    // configuration sequence
    typedef enum logic [1:0] {
        S_POWERUP,
        S_CLEAR,
        S_LOAD,
        S_USER
    } cfg_state_t;

endpackage

// ---- verilog/osc_divider.sv ----
// osc_divider: binary divider on the oscillator with two resynchronised taps.
// assumes clk is the oscillator and rstn is already synchronised.
`timescale 1ns/1ps
module osc_divider
    import global_ctrl_pkg::*;
#(
    parameter int WIDTH = DIV_WIDTH
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic run,
    input wire tap_sel_t selA,
    input wire tap_sel_t selB,
    output logic tapA,
    output logic tapB,
    output logic cfgClkBit
);

    if (WIDTH < TAP3_BIT + 1) begin : g_chk
        $error("osc_divider: WIDTH too small for the highest tap");
    end

    logic [WIDTH-1:0] div;

    // pick the divider bit for a tap choice
    function automatic logic tapBit(input tap_sel_t sel, input logic [WIDTH-1:0] d);
        logic b;
        b = 1'b0;
        case (sel)
            TAP_500K: b = d[TAP0_BIT];
            TAP_16K: b = d[TAP1_BIT];
            TAP_490: b = d[TAP2_BIT];
            default: b = d[TAP3_BIT];
        endcase
        return b;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // binary divider
    // counts only while the oscillator runs
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            div <= '0;
        end else if (run) begin
            div <= div + {{(WIDTH-1){1'b0}}, 1'b1};
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            tapA <= 1'b0;
            tapB <= 1'b0;
        end else begin
            tapA <= run & tapBit(selA, div);
            tapB <= run & tapBit(selB, div);
        end
    end

    assign cfgClkBit = div[CFG_CLK_BIT];

    ////////////////////////////////////////////////////////////////////////////
    // assertions
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    property p_tap_resync;
        run |=> tapA == ($past(run) & tapBit($past(selA), $past(div)));
    endproperty
    a_tap_resync: assert property (p_tap_resync) else $error("tap A not resynced");

    // a genuine rise of the fastest tap lasts eight cycles while the divider runs
    property p_tap_period;
        run && $past(run) && $past(run, 2) && $rose(tapA) && selA == TAP_500K
            && $past(selA) == TAP_500K && $past(selA, 2) == TAP_500K
            ##1 (run && selA == TAP_500K) [*7] |=> !tapA;
    endproperty
    a_tap_period: assert property (p_tap_period) else $error("500k tap period wrong");

endmodule

// ---- verilog/global_ctrl_osc_divider.sv ----
// global_ctrl_osc_divider: oscillator control and divider taps, chip-wide
// preset/clear and output-float nets, long-line tri-state drivers and keepers.
// assumes clk is the on-chip oscillator and all inputs are synchronous to it.
`timescale 1ns/1ps
module global_ctrl_osc_divider
    import global_ctrl_pkg::*;
#(
    parameter int NCELLS = 4,
    parameter int NFLOPS = 8,
    parameter int NPINS = 8,
    parameter int MEM_DEPTH = 16,
    parameter int MEM_AW = 4,
    parameter int POR_CYCLES = POR_CYCLES_DEF
) (
    input wire logic clk,
    input wire logic rstn,
    // configuration sequence
    input wire logic reconfigReq,
    input wire logic masterMode,
    input wire logic loadDone,
    input wire logic oscPrimitiveUsed,
    output logic configDone,
    output logic configurationClock,
    output logic configurationClockOe,
    // oscillator and taps towards user logic
    input wire logic oscRequest,
    input wire tap_sel_t tapSelA,
    input wire tap_sel_t tapSelB,
    output logic oscOut,
    output logic tapA,
    output logic tapB,
    // chip-wide preset/clear sources
    input wire net_src_t presetSrc,
    input wire logic presetPin,
    input wire logic presetNode,
    output logic chipPresetClear,
    // chip-wide output-float sources
    input wire net_src_t floatSrc,
    input wire logic floatPin,
    input wire logic floatNode,
    input wire logic scanEnabled,
    input wire logic scanExtest,
    output logic chipOutputFloat,
    // user flip-flop bank
    input wire logic [NFLOPS-1:0] flopInitSet,
    input wire logic [NFLOPS-1:0] localSetReset,
    input wire logic [NFLOPS-1:0] flopD,
    output logic [NFLOPS-1:0] flopQ,
    // output pins
    input wire logic [NPINS-1:0] userOe,
    input wire logic [NPINS-1:0] userOut,
    output logic [NPINS-1:0] pinOut,
    output logic [NPINS-1:0] pinOe,
    // distributed memory
    input wire logic memWe,
    input wire logic [MEM_AW-1:0] memAddr,
    input wire logic memWdata,
    output logic memRdata,
    // long-line tri-state buffers, one up and one down per cell
    input wire logic [NCELLS-1:0] upIn,
    input wire logic [NCELLS-1:0] upFloat,
    input wire logic [NCELLS-1:0] dnIn,
    input wire logic [NCELLS-1:0] dnFloat,
    output logic lineAbove,
    output logic lineBelow
);

    if (NCELLS < 1 || NFLOPS < 1 || NPINS < 1 || MEM_DEPTH > (1 << MEM_AW)
            || POR_CYCLES < 1 || POR_CYCLES > 65535) begin : g_chk
        $error("global_ctrl_osc_divider: unsupported parameter values");
    end

    ////////////////////////////////////////////////////////////////////////////
    // reset release through two flip-flops
    logic rstMeta;
    logic rstnInt;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rstMeta <= 1'b0;
            rstnInt <= 1'b0;
        end else begin
            rstMeta <= 1'b1;
            rstnInt <= rstMeta;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // configuration sequence
    cfg_state_t state;
    logic [15:0] seqCount;
    logic inUser;
    logic oscRun;
    logic cfgClkBit;

    assign inUser = (state == S_USER);

    // power-on timeout and clear on oscillator
    always_ff @(posedge clk or negedge rstnInt) begin
        if (!rstnInt) begin
            state <= S_POWERUP;
            seqCount <= '0;
        end else begin
            case (state)
                S_POWERUP: begin
                    seqCount <= seqCount + 16'h0001;
                    if (seqCount == 16'(POR_CYCLES - 1)) begin
                        state <= S_CLEAR;
                        seqCount <= '0;
                    end
                end
                S_CLEAR: begin
                    seqCount <= seqCount + 16'h0001;
                    if (seqCount == 16'(CLEAR_CYCLES - 1)) begin
                        state <= S_LOAD;
                        seqCount <= '0;
                    end
                end
                S_LOAD: begin
                    if (loadDone) begin
                        state <= S_USER;
                    end
                end
                default: begin
                    if (reconfigReq) begin
                        state <= S_CLEAR;
                        seqCount <= '0;
                    end
                end
            endcase
        end
    end

    assign configDone = inUser;
    assign oscRun = !inUser || oscPrimitiveUsed;
    always_ff @(posedge clk or negedge rstnInt) begin
        if (!rstnInt) begin
            configurationClock <= 1'b0;
            configurationClockOe <= 1'b0;
        end else begin
            configurationClock <= (state == S_LOAD) & masterMode & cfgClkBit;
            configurationClockOe <= (state == S_LOAD) & masterMode;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // oscillator output and divider taps
    logic oscPass;
    logic tapRawA;
    logic tapRawB;

    always_ff @(posedge clk or negedge rstnInt) begin
        if (!rstnInt) begin
            oscPass <= 1'b0;
        end else begin
            oscPass <= inUser & oscPrimitiveUsed & oscRequest;
        end
    end

    assign oscOut = clk & oscPass;
    osc_divider #(
        .WIDTH(DIV_WIDTH)
    ) u_div (
        .clk(clk),
        .rstn(rstnInt),
        .run(oscRun),
        .selA(tapSelA),
        .selB(tapSelB),
        .tapA(tapRawA),
        .tapB(tapRawB),
        .cfgClkBit(cfgClkBit)
    );
    assign tapA = tapRawA & inUser;
    assign tapB = tapRawB & inUser;
    ////////////////////////////////////////////////////////////////////////////
    // chip-wide nets
    logic presetNet;
    logic floatNet;

    assign presetNet = presetSrc.fromPin ? (presetPin ^ presetSrc.invert) : presetNode;
    assign floatNet = floatSrc.fromPin ? (floatPin ^ floatSrc.invert) : floatNode;

    assign chipPresetClear = !rstnInt || !inUser || presetNet;
    assign chipOutputFloat = floatNet & inUser;

    ////////////////////////////////////////////////////////////////////////////
    // user flip-flop bank
    genvar gi;
    generate
        for (gi = 0; gi < NFLOPS; gi++) begin : g_flop
            always_ff @(posedge clk or negedge rstnInt) begin
                if (!rstnInt) begin
                    flopQ[gi] <= 1'b0;
                end else if (chipPresetClear || localSetReset[gi]) begin
                    flopQ[gi] <= flopInitSet[gi];
                end else begin
                    flopQ[gi] <= flopD[gi];
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // output pins
    logic floatActive;
    // float all outputs except in EXTEST
    assign floatActive = chipOutputFloat && !(scanEnabled && scanExtest);
    always_ff @(posedge clk or negedge rstnInt) begin
        if (!rstnInt) begin
            pinOut <= '0;
            pinOe <= '0;
        end else begin
            pinOut <= userOut;
            pinOe <= floatActive ? '0 : (userOe & {NPINS{inUser}});
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // distributed memory, loaded in configuration or written by user logic
    logic mem [MEM_DEPTH];
    logic memWrite;

    assign memWrite = memWe && (state == S_LOAD || inUser);

    always_ff @(posedge clk) begin
        if (memWrite) begin
            mem[memAddr] <= memWdata;
        end
    end

    always_ff @(posedge clk or negedge rstnInt) begin
        if (!rstnInt) begin
            memRdata <= 1'b0;
        end else begin
            memRdata <= mem[memAddr];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // long lines with keepers
    logic drivenAbove;
    logic drivenBelow;
    logic valueAbove;
    logic valueBelow;
    logic keepAbove;
    logic keepBelow;

    // up buffers above, down buffers below
    // float on 1, drive on 0
    assign drivenAbove = |(~upFloat);
    assign drivenBelow = |(~dnFloat);
    assign valueAbove = |(upIn & ~upFloat);
    assign valueBelow = |(dnIn & ~dnFloat);

    always_ff @(posedge clk or negedge rstnInt) begin
        if (!rstnInt) begin
            keepAbove <= 1'b0;
            keepBelow <= 1'b0;
        end else begin
            keepAbove <= lineAbove;
            keepBelow <= lineBelow;
        end
    end

    // any active buffer overrides the keeper
    assign lineAbove = drivenAbove ? valueAbove : keepAbove;
    assign lineBelow = drivenBelow ? valueBelow : keepBelow;

    ////////////////////////////////////////////////////////////////////////////
    // assertions
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstnInt);

    property p_preset_cfg; !inUser |-> chipPresetClear; endproperty
    a_preset_cfg: assert property (p_preset_cfg) else $error("preset low in config");
    property p_flop_dir; chipPresetClear |=> flopQ == $past(flopInitSet); endproperty
    a_flop_dir: assert property (p_flop_dir) else $error("flop not forced by preset");
    property p_float_pins; floatActive |=> pinOe == '0; endproperty
    a_float_pins: assert property (p_float_pins) else $error("pin driven while float");
    property p_extest_pass;
        inUser && scanEnabled && scanExtest |=> pinOe == $past(userOe);
    endproperty
    a_extest_pass: assert property (p_extest_pass) else $error("extest pins floated");
    property p_float_src;
        inUser && floatSrc.fromPin |-> chipOutputFloat == (floatPin ^ floatSrc.invert);
    endproperty
    a_float_src: assert property (p_float_src) else $error("float pin sense wrong");
    property p_line_drive; upFloat[0] == 1'b0 && upIn[0] |-> lineAbove; endproperty
    a_line_drive: assert property (p_line_drive) else $error("active buffer lost");
    property p_keeper; &dnFloat ##1 &dnFloat |-> lineBelow == $past(lineBelow); endproperty
    a_keeper: assert property (p_keeper) else $error("keeper lost level");
    property p_osc_stop;
        inUser && !oscPrimitiveUsed ##1 inUser |-> !tapA && !tapB && !oscPass;
    endproperty
    a_osc_stop: assert property (p_osc_stop) else $error("oscillator not stopped");
    property p_osc_req; oscPass |-> $past(oscRequest) && $past(inUser); endproperty
    a_osc_req: assert property (p_osc_req) else $error("oscillator out unrequested");
    property p_mem_keep;
        presetNet && !memWrite && !$past(memWrite) && $stable(memAddr) |=> $stable(memRdata);
    endproperty
    a_mem_keep: assert property (p_mem_keep) else $error("memory changed by preset");
    property p_por_len; $rose(rstnInt) |-> (state == S_POWERUP) [*8]; endproperty
    a_por_len: assert property (p_por_len) else $error("power-on timeout too short");

    c_user: cover property (state == S_LOAD ##1 inUser);
    c_reconfig: cover property (inUser && reconfigReq ##1 state == S_CLEAR);
    c_net_preset: cover property (inUser && presetNet ##1 flopQ == $past(flopInitSet));
    c_keep: cover property (drivenAbove ##1 !drivenAbove);
endmodule

// ---- dv/fabric_drv.sv ----
// fabric_drv: user logic driving the chip-wide control nets.
// assumes its inputs change just after a rising clock edge.
`timescale 1ns/1ps
module fabric_drv
    import global_ctrl_pkg::*;
(
    input wire logic wantPreset,
    input wire logic wantFloat,
    input wire net_src_t presetMode,
    input wire net_src_t floatMode,
    output net_src_t presetSrc,
    output logic presetPin,
    output logic presetNode,
    output net_src_t floatSrc,
    output logic floatPin,
    output logic floatNode
);
    ////////////////////////////////////////////////////////////
    // pin or node drive
    always_comb begin
        presetSrc = presetMode;
        presetPin = presetMode.fromPin ? wantPreset ^ presetMode.invert : !wantPreset;
        presetNode = presetMode.fromPin ? !wantPreset : wantPreset;
    end
    always_comb begin
        floatSrc = floatMode;
        floatPin = floatMode.fromPin ? wantFloat ^ floatMode.invert : !wantFloat;
        floatNode = floatMode.fromPin ? !wantFloat : wantFloat;
    end
endmodule

// ---- dv/testbench.sv ----
// testbench: self-checking bench for the global control block.
// assumes a 250 MHz clk and a power-on count shortened to 20.
`timescale 1ns/1ps
module testbench
    import global_ctrl_pkg::*;
;
    localparam int LIMIT = 60000;
    logic clk, rstn, reconfigReq, masterMode, loadDone, oscPrimitiveUsed, oscRequest, memWe;
    logic scanEnabled, scanExtest, memWdata, wantPreset, wantFloat, presetPin, presetNode;
    logic floatPin, floatNode, configDone, configurationClock, configurationClockOe, oscOut;
    logic tapA, tapB, chipPresetClear, chipOutputFloat, memRdata, lineAbove, lineBelow;
    logic [3:0] memAddr, upIn, upFloat, dnIn, dnFloat;
    logic [7:0] flopInitSet, localSetReset, flopD, flopQ, userOe, userOut, pinOut, pinOe;
    logic [1:0] modes [3] = '{2'h0, 2'h2, 2'h3};
    tap_sel_t tapSelA, tapSelB;
    net_src_t presetSrc, floatSrc, presetMode, floatMode;
    int fails = 0;
    int checks = 0;
    int cycles = 0;

    ////////////////////////////////////////////////////////////
    // block and fabric model
    global_ctrl_osc_divider #(.POR_CYCLES(20)) uut (
        .clk(clk), .rstn(rstn), .reconfigReq(reconfigReq), .masterMode(masterMode),
        .loadDone(loadDone), .oscPrimitiveUsed(oscPrimitiveUsed), .configDone(configDone),
        .configurationClock(configurationClock), .configurationClockOe(configurationClockOe),
        .oscRequest(oscRequest), .tapSelA(tapSelA), .tapSelB(tapSelB), .oscOut(oscOut),
        .tapA(tapA), .tapB(tapB), .presetSrc(presetSrc), .presetPin(presetPin),
        .presetNode(presetNode), .chipPresetClear(chipPresetClear), .floatSrc(floatSrc),
        .floatPin(floatPin), .floatNode(floatNode), .scanEnabled(scanEnabled),
        .scanExtest(scanExtest), .chipOutputFloat(chipOutputFloat), .flopD(flopD),
        .flopInitSet(flopInitSet), .localSetReset(localSetReset), .flopQ(flopQ),
        .userOe(userOe), .userOut(userOut), .pinOut(pinOut), .pinOe(pinOe),
        .memWe(memWe), .memAddr(memAddr), .memWdata(memWdata), .memRdata(memRdata),
        .upIn(upIn), .upFloat(upFloat), .dnIn(dnIn), .dnFloat(dnFloat),
        .lineAbove(lineAbove), .lineBelow(lineBelow)
    );
    fabric_drv fabric (
        .wantPreset(wantPreset), .wantFloat(wantFloat), .presetMode(presetMode),
        .floatMode(floatMode), .presetSrc(presetSrc), .presetPin(presetPin),
        .presetNode(presetNode), .floatSrc(floatSrc), .floatPin(floatPin), .floatNode(floatNode)
    );

    ////////////////////////////////////////////////////////////
    // clock and hang guard
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            fails = fails + 1;
            give_verdict();
        end
    end

    // compare, wait, close
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks = checks + 1;
        if (got !== exp) begin
            fails = fails + 1;
            $display("unexpected at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic give_verdict();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////
    // power-up, clear, master load, user state
    task automatic t_cfg();
        int n;
        logic a;
        n = 2;
        step(2);
        chk(chipPresetClear, 1'b1);
        while (configurationClockOe !== 1'b1 && n < 1000) begin
            step(1);
            n++;
        end
        chk(n >= 518 && n <= 528, 1'b1);
        a = configurationClock;
        step(1);
        chk(configurationClock, !a);
        @(posedge clk);
        loadDone <= 1'b1;
        step(3);
        chk({configDone, configurationClockOe, chipPresetClear}, 3'h4);
        $display("done configuration");
    endtask

    // steady level of one tap must last exactly half
    task automatic half(input logic b, input int h);
        logic t0;
        int n;
        for (int k = 0; k < 2; k++) begin
            t0 = b ? tapB : tapA;
            n = 0;
            while ((b ? tapB : tapA) === t0 && n < 2 * h + 4) begin
                step(1);
                n++;
            end
        end
        chk(n[15:0], h[15:0]);
    endtask
    task automatic t_taps();
        @(posedge clk);
        tapSelA <= TAP_500K;
        tapSelB <= TAP_16K;
        step(2);
        half(1'b0, 1 << TAP0_BIT);
        half(1'b1, 1 << TAP1_BIT);
        @(posedge clk);
        tapSelA <= TAP_490;
        tapSelB <= TAP_15;
        step(2);
        half(1'b0, 1 << TAP2_BIT);
        $display("done taps");
    endtask

    // undivided output gating and oscillator stop
    task automatic t_osc();
        step(3);
        chk(oscOut, 1'b0);
        @(posedge clk);
        oscRequest <= 1'b1;
        tapSelA <= TAP_500K;
        step(3);
        chk(oscOut, 1'b1);
        @(posedge clk);
        oscPrimitiveUsed <= 1'b0;
        step(3);
        for (int k = 0; k < 20; k++) begin
            chk({oscOut, tapA}, 2'h0);
            step(1);
        end
        @(posedge clk);
        oscPrimitiveUsed <= 1'b1;
        $display("done oscillator");
    endtask

    // preset from every source, memory kept
    task automatic t_preset();
        @(posedge clk);
        {memWe, memAddr, memWdata} <= 6'h2b;
        {flopInitSet, flopD} <= 16'ha53c;
        @(posedge clk);
        memWe <= 1'b0;
        for (int m = 0; m < 3; m++) begin
            @(posedge clk);
            presetMode <= net_src_t'(modes[m]);
            wantPreset <= 1'b1;
            step(1);
            chk({memRdata, chipPresetClear, flopQ}, 10'h3a5);
            @(posedge clk);
            wantPreset <= 1'b0;
            step(1);
            chk({chipPresetClear, flopQ}, 9'h03c);
        end
        @(posedge clk);
        localSetReset <= 8'h0f;
        step(1);
        chk(flopQ, (8'ha5 & 8'h0f) | (8'h3c & 8'hf0));
        @(posedge clk);
        localSetReset <= 8'h00;
        $display("done preset");
    endtask

    // output float from every source, scan exemption
    task automatic t_float();
        @(posedge clk);
        {userOe, userOut} <= 16'hff55;
        step(2);
        chk({pinOe, pinOut}, 16'hff55);
        for (int m = 0; m < 3; m++) begin
            @(posedge clk);
            floatMode <= net_src_t'(modes[m]);
            wantFloat <= 1'b1;
            step(1);
            chk({chipOutputFloat, pinOe}, 9'h100);
            @(posedge clk);
            {wantFloat, scanEnabled, scanExtest} <= {1'b1, m == 2, m == 2};
            step(2);
            chk(pinOe, m == 2 ? 8'hff : 8'h00);
            @(posedge clk);
            {wantFloat, scanEnabled, scanExtest} <= 3'h0;
        end
        $display("done float");
    endtask

    // long-line buffers and keepers
    task automatic t_lines();
        @(posedge clk);
        {upIn, upFloat} <= 8'hbb;
        step(1);
        chk(lineAbove, 1'b0);
        @(posedge clk);
        upIn <= 4'h4;
        step(1);
        chk(lineAbove, 1'b1);
        @(posedge clk);
        upFloat <= 4'hf;
        step(3);
        chk(lineAbove, 1'b1);
        @(posedge clk);
        {upIn, upFloat, dnIn, dnFloat} <= 16'h0e87;
        step(1);
        chk({lineAbove, lineBelow}, 2'h1);
        @(posedge clk);
        {upFloat, dnIn, dnFloat} <= 12'hf0f;
        step(3);
        chk({lineAbove, lineBelow}, 2'h1);
        $display("done lines");
    endtask

    // reconfiguration presets flops and returns
    task automatic t_reconfig();
        int n;
        n = 0;
        @(posedge clk);
        reconfigReq <= 1'b1;
        {masterMode, loadDone} <= 2'h0;
        @(posedge clk);
        reconfigReq <= 1'b0;
        step(2);
        chk({configDone, chipPresetClear, flopQ}, 10'h1a5);
        // slave load keeps the configuration clock idle
        repeat (520) begin
            step(1);
            n = n + int'({configurationClock, configurationClockOe} !== 2'h0);
        end
        chk({configDone, n[14:0]}, 16'h0000);
        @(posedge clk);
        loadDone <= 1'b1;
        n = 0;
        while (configDone !== 1'b1 && n < 1000) begin
            step(1);
            n++;
        end
        chk(configDone, 1'b1);
        $display("done reconfiguration");
    endtask

    ////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        rstn = 1'b0;
        {reconfigReq, loadDone, oscRequest, scanEnabled, scanExtest} = 5'h0;
        {memWe, memWdata, wantPreset, wantFloat, masterMode, oscPrimitiveUsed} = 6'h3;
        {flopInitSet, localSetReset, flopD, userOe, userOut} = '0;
        {memAddr, upIn, dnIn, upFloat, dnFloat} = 20'h000ff;
        tapSelA = TAP_500K;
        tapSelB = TAP_500K;
        presetMode = '0;
        floatMode = '0;
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        t_cfg();
        t_taps();
        t_osc();
        t_preset();
        t_float();
        t_lines();
        t_reconfig();
        give_verdict();
    end
endmodule
